// *** rtl/prl_pkg.sv ***
// Constants and types shared by the probe rising-edge latch.
package prl_pkg;
    localparam int unsigned POS_W          = 32;
    localparam int unsigned FLAG_W         = 16;
    localparam int unsigned FLAG_BIT       = 0;
    localparam int unsigned SBIT_SEL_W     = 4;
    localparam int unsigned SBIT_N         = 16;
    localparam logic [15:0] FLAG_RESET     = 16'h0000;
    localparam logic [31:0] POS_RESET      = 32'h0000_0000;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    localparam int unsigned STAT_RISE_BIT  = 0;
    localparam int unsigned STAT_FALL_BIT  = 1;
    localparam int unsigned SYNC_STAGES    = 2;

    typedef enum logic [1:0] {
        PRL_IDLE  = 2'b00,
        PRL_ARMED = 2'b01,
        PRL_DONE  = 2'b11
    } prl_state_e;
endpackage

// *** rtl/prl_sync.sv ***
// Two-stage synchroniser with a registered edge detector behind it.
`timescale 1ns/1ps
`default_nettype none
module prl_sync
(
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Signal.
    input  wire logic din,
    output logic      level,
    output logic      rise
);
    typedef struct packed {
        logic [prl_pkg::SYNC_STAGES-1:0] sh;
        logic                            last;
    } prl_sync_s;

    prl_sync_s st_r;
    prl_sync_s st_nxt;

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.sh   = {st_r.sh[0], din};
        st_nxt.last = st_r.sh[1];
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.sh[1];
    // A low sample followed by a high one gives a single pulse.
    assign rise  = st_r.sh[1] & ~st_r.last;
endmodule
`default_nettype wire

// *** rtl/prl_latch.sv ***
// Probe one rising-edge latch with position capture and status routing.
`timescale 1ns/1ps
`default_nettype none
module prl_latch
(
    // Clock and reset.
    input  wire logic                              core_clk,
    input  wire logic                              arst_n,
    // Control from the motion control unit.
    input  wire logic                              cycle_active,
    input  wire logic                              probe_arm,
    input  wire logic                              fall_event,
    input  wire logic [prl_pkg::SBIT_SEL_W-1:0]    rt_bit_sel,
    input  wire logic                              rt_bit_en,
    // Probe pin and position feedback.
    input  wire logic                              probe_in,
    input  wire logic [prl_pkg::POS_W-1:0]         pos_fb,
    // Status toward the telegram.
    output logic [prl_pkg::FLAG_W-1:0]             probe1_rise_latched_flag,
    output logic [prl_pkg::POS_W-1:0]              rise_pos_value,
    output logic [prl_pkg::FLAG_W-1:0]             probe_status,
    output logic [prl_pkg::SBIT_N-1:0]             rt_status
);
    ////////////////////////////////////////////////////////////////////////
    logic rst_q1;
    logic rst_n;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    logic probe_rise;
    prl_sync u_sync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      (probe_in),
        .level    (),
        .rise     (probe_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        prl_pkg::prl_state_e          state;
        logic                         arm_last;
        logic [prl_pkg::FLAG_W-1:0]   flag;
        logic [prl_pkg::POS_W-1:0]    pos;
        logic [prl_pkg::FLAG_W-1:0]   stat;
        logic [prl_pkg::SBIT_N-1:0]   rt;
    } prl_latch_s;

    prl_latch_s st_r;
    prl_latch_s st_nxt;

    function automatic logic [prl_pkg::SBIT_N-1:0] onehot
    (
        input logic [prl_pkg::SBIT_SEL_W-1:0] sel
    );
        logic [prl_pkg::SBIT_N-1:0] v;
        v      = '0;
        v[sel] = 1'b1;
        return v;
    endfunction

    logic arm_seen;
    logic arm_drop;
    logic capture;

    // The arm input counts only inside an active probing cycle.
    assign arm_seen = cycle_active & probe_arm;
    assign arm_drop = cycle_active & st_r.arm_last & ~probe_arm;
    // Capture needs cycle, arm and a fresh edge in a waiting state.
    assign capture  = arm_seen & probe_rise
                    & (st_r.state == prl_pkg::PRL_ARMED);

    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.arm_last = cycle_active ? probe_arm : st_r.arm_last;
        case (st_r.state)
            prl_pkg::PRL_IDLE:
            begin
                if (arm_seen)
                begin
                    st_nxt.state = prl_pkg::PRL_ARMED;
                end
            end
            prl_pkg::PRL_ARMED:
            begin
                if (capture)
                begin
                    st_nxt.state = prl_pkg::PRL_DONE;
                end
                else if (arm_drop)
                begin
                    st_nxt.state = prl_pkg::PRL_IDLE;
                end
            end
            prl_pkg::PRL_DONE:
            begin
                // Another capture only after the arm goes low again.
                if (arm_drop)
                begin
                    st_nxt.state = prl_pkg::PRL_IDLE;
                end
            end
            default:
            begin
                st_nxt.state = prl_pkg::PRL_IDLE;
            end
        endcase
        if (capture)
        begin
            st_nxt.flag[prl_pkg::FLAG_BIT] = 1'b1;
            st_nxt.pos                     = pos_fb;
        end
        // The flag is not touched when the cycle ends, so it holds.
        if (arm_drop)
        begin
            st_nxt.stat[prl_pkg::STAT_RISE_BIT] = 1'b0;
            st_nxt.stat[prl_pkg::STAT_FALL_BIT] = 1'b0;
        end
        else
        begin
            if (capture)
            begin
                st_nxt.stat[prl_pkg::STAT_RISE_BIT] = 1'b1;
            end
            if (cycle_active & fall_event)
            begin
                st_nxt.stat[prl_pkg::STAT_FALL_BIT] = 1'b1;
            end
        end
        // Routed flag copy on the selected real-time status bit.
        st_nxt.rt = rt_bit_en
            ? (onehot(rt_bit_sel)
               & {prl_pkg::SBIT_N{st_nxt.flag[prl_pkg::FLAG_BIT]}})
            : '0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r.state    <= prl_pkg::PRL_IDLE;
            st_r.arm_last <= 1'b0;
            st_r.flag     <= prl_pkg::FLAG_RESET;
            st_r.pos      <= prl_pkg::POS_RESET;
            st_r.stat     <= prl_pkg::STATUS_RESET;
            st_r.rt       <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign probe1_rise_latched_flag = st_r.flag;
    assign rise_pos_value           = st_r.pos;
    assign probe_status             = st_r.stat;
    assign rt_status                = st_r.rt;

    ////////////////////////////////////////////////////////////////////////
    // The flag never sets without an armed, active cycle edge.
    sequence s_capture;
        cycle_active && probe_arm && probe_rise;
    endsequence

    property p_flag_cause;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(st_r.flag[prl_pkg::FLAG_BIT]) |-> $past(capture);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("flag set without armed edge");

    property p_pos_cap;
        @(posedge core_clk) disable iff (!rst_n)
        capture |=> (rise_pos_value == $past(pos_fb));
    endproperty
    a_pos_cap: assert property (p_pos_cap)
        else $error("position not captured with flag");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !cycle_active |=> $stable(probe1_rise_latched_flag);
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag changed outside probing cycle");

    property p_route;
        @(posedge core_clk) disable iff (!rst_n)
        rt_bit_en ##1 $stable(rt_bit_sel) |->
            (rt_status[$past(rt_bit_sel)] == probe1_rise_latched_flag[0]);
    endproperty
    a_route: assert property (p_route)
        else $error("routed status bit differs from flag");

    property p_clear;
        @(posedge core_clk) disable iff (!rst_n)
        arm_drop |=> (probe_status[1:0] == 2'b00);
    endproperty
    a_clear: assert property (p_clear)
        else $error("status bits not cleared on disarm");

    property p_rearm;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.state == prl_pkg::PRL_DONE) && !arm_drop
            |=> (st_r.state == prl_pkg::PRL_DONE);
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("left done state without disarm");

    property p_ignore;
        @(posedge core_clk) disable iff (!rst_n)
        !cycle_active |=> $stable(st_r.state);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("arm acted on outside probing cycle");

    property p_edge;
        @(posedge core_clk) disable iff (!rst_n)
        probe_rise |=> !probe_rise;
    endproperty
    a_edge: assert property (p_edge)
        else $error("edge pulse longer than one cycle");

    property p_cap_seq;
        @(posedge core_clk) disable iff (!rst_n)
        s_capture and (st_r.state == prl_pkg::PRL_ARMED)
            |=> probe1_rise_latched_flag[0] && probe_status[0];
    endproperty
    a_cap_seq: assert property (p_cap_seq)
        else $error("armed edge did not set flag");
endmodule
`default_nettype wire

// *** verif/prl_mcu_model.sv ***
// Behavioural motion control unit driving the probing controls.
`timescale 1ns/1ps
`default_nettype none
module prl_mcu_model
(
    // Clock.
    input  wire logic                           core_clk,
    // Controls toward the latch.
    output logic                                cycle_active,
    output logic                                probe_arm,
    output logic                                fall_event,
    output logic [prl_pkg::SBIT_SEL_W-1:0]      rt_bit_sel,
    output logic                                rt_bit_en
);
    initial
    begin
        cycle_active = 1'b0;
        probe_arm = 1'b0;
        fall_event = 1'b0;
        rt_bit_sel = 4'h0;
        rt_bit_en = 1'b0;
    end
    task automatic step();
        @(posedge core_clk);
        #2;
    endtask
    task automatic set_cycle(input logic v);
        step();
        cycle_active = v;
    endtask
    task automatic set_arm(input logic v);
        step();
        probe_arm = v;
    endtask
    // Another capture on the same edge needs arm low, then high again.
    task automatic rearm();
        set_arm(1'b0);
        set_arm(1'b1);
    endtask
    task automatic pulse_fall();
        step();
        fall_event = 1'b1;
        step();
        fall_event = 1'b0;
    endtask
    task automatic route(input logic en, input logic [3:0] sel);
        step();
        rt_bit_en = en;
        rt_bit_sel = sel;
    endtask
endmodule
`default_nettype wire

// *** verif/prl_latch_tb_top.sv ***
// Self-checking bench for the probe rising-edge latch.
`timescale 1ns/1ps
`default_nettype none
module prl_latch_tb_top;
    typedef struct packed
    {
        logic [15:0] f;
        logic [31:0] p;
        logic [15:0] s;
        logic [15:0] r;
    } prl_tb_exp_s;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        probe_in = 1'b0;
    logic [31:0] pos_fb = 32'h0;
    logic        cyc, arm, fev, en;
    logic [3:0]  sel;
    logic [15:0] flag, stat, rt;
    logic [31:0] pos;
    logic [79:0] prev = 80'h0;
    logic        live = 1'b0;
    logic        ef = 1'b0;
    logic        een = 1'b0;
    logic [3:0]  esel = 4'h0;
    logic [31:0] ep = 32'h0;
    logic [15:0] es = 16'h0;
    int          n_fail = 0;
    int          cmp_count = 0;
    prl_tb_exp_s q[$];
    prl_tb_exp_s e;
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end
    prl_mcu_model u_mcu (.core_clk(core_clk), .cycle_active(cyc),
        .probe_arm(arm), .fall_event(fev), .rt_bit_sel(sel),
        .rt_bit_en(en));
    prl_latch u_dut (.core_clk(core_clk), .arst_n(arst_n),
        .cycle_active(cyc), .probe_arm(arm), .fall_event(fev),
        .rt_bit_sel(sel), .rt_bit_en(en), .probe_in(probe_in),
        .pos_fb(pos_fb), .probe1_rise_latched_flag(flag),
        .rise_pos_value(pos), .probe_status(stat), .rt_status(rt));
    task automatic stop_test();
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic note();
        e.f = {15'h0, ef};
        e.p = ep;
        e.s = es;
        e.r = (een && ef) ? (16'h0001 << esel) : 16'h0000;
        q.push_back(e);
    endtask
    task automatic step();
        @(posedge core_clk);
        #2;
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 40 && q.size() != 0; i++)
            step();
        if (q.size() != 0)
        begin
            check("pending results", q.size(), 0);
            stop_test();
        end
    endtask
    // Holding the probe high for several cycles must still give one event.
    task automatic probe(input logic [31:0] p);
        step();
        pos_fb = p;
        probe_in = 1'b1;
        repeat (6) step();
        probe_in = 1'b0;
        pos_fb = ~p;
        repeat (4) step();
        wait_done();
    endtask
    // Any change at the outputs is one result, matched to the oldest note.
    always @(posedge core_clk)
    begin
        #1;
        if (live && {flag, pos, stat, rt} !== prev)
        begin
            prev = {flag, pos, stat, rt};
            if (q.size() == 0)
                check("unnoted change", 1, 0);
            else
            begin
                e = q.pop_front();
                check("flag", flag, e.f);
                check("pos", pos, e.p);
                check("status", stat, e.s);
                check("rt", rt, e.r);
            end
        end
    end
    initial
    begin
        void'($urandom(32'h9c64));
        repeat (12) @(posedge core_clk);
        #2;
        arst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check("flag at reset", flag, 0);
        check("status at reset", {stat, rt}, 0);
        live = 1'b1;
        een = 1'b1;
        esel = 4'($urandom_range(15, 0));
        u_mcu.route(1'b1, esel);
        // Arm without a probing cycle is ignored.
        u_mcu.set_arm(1'b1);
        probe($urandom());
        check("flag idle", flag, 0);
        check("status idle", stat, 0);
        u_mcu.set_arm(1'b0);
        u_mcu.set_cycle(1'b1);
        u_mcu.set_arm(1'b1);
        ef = 1'b1;
        es = 16'h0001;
        ep = $urandom();
        note();
        probe(ep);
        probe($urandom());
        es = 16'h0003;
        note();
        u_mcu.pulse_fall();
        wait_done();
        es = 16'h0000;
        note();
        u_mcu.rearm();
        wait_done();
        es = 16'h0001;
        ep = $urandom();
        note();
        probe(ep);
        u_mcu.set_cycle(1'b0);
        u_mcu.rearm();
        probe($urandom());
        check("flag held", flag, 32'h0000_0001);
        check("pos held", pos, ep);
        esel = esel + 4'h1;
        note();
        u_mcu.route(1'b1, esel);
        wait_done();
        een = 1'b0;
        note();
        u_mcu.route(1'b0, esel);
        wait_done();
        stop_test();
    end
endmodule
`default_nettype wire
